// ==== eakl_top.sv ====
// Egress ACL key lookup: rule selection, key building and table search
// for two parallel engines, with an AXI4-Lite port that fills the tables.
// Assumes decoded fields and forwarding result arrive on the core clock.
`timescale 1ns/1ps
`default_nettype none
`include "eakl_consts.svh"
//
// Summary of operation
// (RULE1) Two independent engines, one lookup each per packet, run side by side.
// (RULE2) Results of all engines are merged after search; several actions may apply.
// (RULE3) Engine 0 keys are at most 135 bits, at most 7 fields per rule.
// (RULE4) Engine 0 has hash plus 16 ternary entries; engine 1 540-bit keys, ternary only.
// (RULE5) Ternary entries mask per entry; a hash table uses one common mask.
// (RULE6) Selector compares forwarding result fields under a per-bit mask.
// (RULE7) Selector scans from entry 15 down to entry 0; lowest hit picks answer at same index.
// (RULE8) No selector hit gives rule pointer 0; a lookup always happens.
// (RULE9) Each engine owns its rule setup table and rule pointers.
// (RULE10) Rule pointer indexes rule setup; bit n of choice selects field n.
// (RULE11) Valid bits sit lowest, one per field; field data follows in order.
// (RULE12) Keys from packets carry valid bits reflecting that packet.
// (RULE13) Two d-left indexes per key: one small table, one large table.
// (RULE14) Stored match value must equal the built key for a hit.
// (RULE15) A field only matches when the decoder found its protocol.
// (RULE16) Bits 0-3 pick MAC DA, MAC SA, IPv4 SA, IPv4 DA.
// (RULE17) Bits 4-7 pick IPv6 SA, IPv6 DA, L4 source and destination ports.
// (RULE18) Bits 8-10 pick VLAN group pointer, VLAN ID, multicast pointer.
// (RULE19) Bits 11-13 pick port bitmap, L4 protocol byte, Ethernet type.
// (RULE20) Bits 14-17 pick L4 type, L3 type, origin port, rule pointer.
// (RULE21) L4 and L3 type encodings as decoded; used to judge field validity.
// (RULE22) Engine search mask is applied to the key before hashing.
// (RULE23) Key bits above the last selected field are zero.
// (RULE24) Software must store keys built in the same order as the device.
module eakl_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pkt_valid,
  input wire eakl_pkg::eakl_pkt_t pkt_in,
  input wire eakl_pkg::eakl_fwd_t fwd_in,
  output logic res_valid,
  output eakl_pkg::eakl_res_t res_out,
  input wire logic [`EAKL_ADDRW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`EAKL_ADDRW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import eakl_pkg::*;
  localparam int FW [`EAKL_NFLD] = `EAKL_FW_LIST;

  eakl_state_t st, nx;
  // Tables; filled only through the staging window
  logic [`EAKL_SELW-1:0] sel_val [`EAKL_NSEL];
  logic [`EAKL_SELW-1:0] sel_msk [`EAKL_NSEL];
  logic [`EAKL_NSEL-1:0] sel_vld;
  logic [`EAKL_RPW-1:0] sel_ans [2][`EAKL_NSEL];
  logic [`EAKL_CHW-1:0] rule_tab [2][`EAKL_NRULE];
  logic [`EAKL_KW0-1:0] smask0;
  eakl_hent_t small0 [`EAKL_NSMALL];
  eakl_hent_t large0 [`EAKL_NLARGE];
  logic [`EAKL_NSMALL-1:0] small_vld;
  logic [`EAKL_NLARGE-1:0] large_vld;
  logic [`EAKL_KW0-1:0] t0_val [`EAKL_NTERN];
  logic [`EAKL_KW0-1:0] t0_msk [`EAKL_NTERN];
  logic [`EAKL_ANSW-1:0] t0_ans [`EAKL_NTERN];
  logic [`EAKL_KW1-1:0] t1_val [`EAKL_NTERN];
  logic [`EAKL_KW1-1:0] t1_msk [`EAKL_NTERN];
  logic [`EAKL_ANSW-1:0] t1_ans [`EAKL_NTERN];
  logic [`EAKL_NTERN-1:0] t0_vld, t1_vld;

  logic sel_hit;
  logic [3:0] sel_idx;
  logic [`EAKL_RPW-1:0] ptr [2];
  logic [`EAKL_KW1-1:0] kraw0, kraw1;
  logic [`EAKL_SIW-1:0] sidx;
  logic [`EAKL_LIW-1:0] sfold;
  logic [`EAKL_LIW-1:0] lidx;
  logic [`EAKL_KW0-1:0] mkey0;
  logic [3:0] hits;
  logic [`EAKL_ANSW-1:0] act;
  logic [`EAKL_ANSW-1:0] tans0, tans1;

  ////////////////////////////////////////////////////////////////////////////
  // Field data, zero-extended to the widest field (see RULE16)
  function automatic logic [`EAKL_FDW-1:0] fdata(input eakl_pkt_t p, input int f,
      input logic [`EAKL_RPW-1:0] rp);
    logic [`EAKL_FDW-1:0] d;
    d = '0;
    unique case (f)
      0: d[47:0] = p.mac_da; // see RULE16
      1: d[47:0] = p.mac_sa;
      2: d[31:0] = p.ipv4_sa;
      3: d[31:0] = p.ipv4_da;
      4: d = p.ipv6_sa; // see RULE17
      5: d = p.ipv6_da;
      6: d[15:0] = p.l4_sp;
      7: d[15:0] = p.l4_dp;
      8: d[11:0] = p.vlan_group_pointer; // see RULE18
      9: d[11:0] = p.vid;
      10: d[5:0] = p.mc_ptr;
      11: d[10:0] = p.egress_port_bitmap; // see RULE19
      12: d[7:0] = p.l4_proto;
      13: d[15:0] = p.eth_type;
      14: d[2:0] = p.l4_type; // see RULE20
      15: d[1:0] = p.l3_type;
      16: d[3:0] = p.origin_port;
      default: d[`EAKL_RPW-1:0] = rp;
    endcase
    return d;
  endfunction

  // Field validity from the decoder's L3/L4 types and mc_used flag (see RULE15) (see RULE21)
  function automatic logic fvalid(input eakl_pkt_t p, input int f);
    logic ip4, ip6, tu;
    ip4 = (p.l3_type == `EAKL_L3_IPV4);
    ip6 = (p.l3_type == `EAKL_L3_IPV6);
    tu = (ip4 || ip6) && (p.l4_type == `EAKL_L4_UDP || p.l4_type == `EAKL_L4_TCP);
    if (f == 2 || f == 3) return ip4;
    if (f == 4 || f == 5) return ip6;
    if (f == 6 || f == 7) return tu;
    if (f == 10) return p.mc_used;
    if (f == 12) return ip4 || ip6;
    return 1'b1;
  endfunction

  // Key: valid bits lowest, then fields in ascending choice order
  function automatic logic [`EAKL_KW1-1:0] build_key(input eakl_pkt_t p,
      input logic [`EAKL_CHW-1:0] ch, input logic [`EAKL_RPW-1:0] rp, input int maxf);
    logic [`EAKL_KW1-1:0] k;
    int n, vi, pos;
    k = '0;
    n = 0;
    vi = 0;
    for (int f = 0; f < `EAKL_NFLD; f++) begin
      if (ch[f] && n < maxf) n++; // see RULE3
    end
    pos = n;
    for (int f = 0; f < `EAKL_NFLD; f++) begin
      if (ch[f] && vi < maxf) begin // see RULE10
        k[vi] = fvalid(p, f); // see RULE11 see RULE12
        k = k | ({{(`EAKL_KW1 - `EAKL_FDW){1'b0}}, fdata(p, f, rp)} << pos);
        pos += FW[f];
        vi++;
      end
    end
    return k; // Upper bits stay zero (see RULE23)
  endfunction

  // XOR fold of a key into an index of w bits
  function automatic logic [`EAKL_LIW-1:0] fold(input logic [`EAKL_KW0-1:0] k, input int w);
    logic [`EAKL_LIW-1:0] h;
    h = '0;
    for (int i = 0; i < `EAKL_KW0; i++) h[i % w] = h[i % w] ^ k[i];
    return h;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Rule selector: descending scan so the lowest hit wins (see RULE6) (see RULE7)
  always_comb begin
    sel_hit = 1'b0;
    sel_idx = 4'h0;
    for (int i = `EAKL_NSEL - 1; i >= 0; i--) begin
      if (sel_vld[i] && ((fwd_in ^ sel_val[i]) & sel_msk[i]) == '0) begin
        sel_hit = 1'b1;
        sel_idx = 4'(i);
      end
    end
    for (int e = 0; e < 2; e++) ptr[e] = sel_hit ? sel_ans[e][sel_idx] : '0; // see RULE8 see RULE9
    kraw0 = build_key(pkt_in, rule_tab[0][ptr[0]], ptr[0], `EAKL_MAXF0); // see RULE1
    kraw1 = build_key(pkt_in, rule_tab[1][ptr[1]], ptr[1], `EAKL_MAXF1);
  end

  // Search stage: d-left hash on masked key, ternary on raw key (see RULE4)
  always_comb begin
    mkey0 = st.key0 & smask0; // see RULE22 see RULE5
    sfold = fold(mkey0, `EAKL_SIW);
    sidx = sfold[`EAKL_SIW-1:0]; // see RULE13
    lidx = fold({mkey0[66:0], mkey0[134:67]}, `EAKL_LIW);
    hits = 4'h0;
    tans0 = '0;
    tans1 = '0;
    hits[0] = small_vld[sidx] && small0[sidx].key == mkey0; // see RULE14
    hits[1] = large_vld[lidx] && large0[lidx].key == mkey0;
    for (int i = `EAKL_NTERN - 1; i >= 0; i--) begin
      if (t0_vld[i] && ((st.key0 ^ t0_val[i]) & t0_msk[i]) == '0) begin
        hits[2] = 1'b1;
        tans0 = t0_ans[i];
      end
      if (t1_vld[i] && ((st.key1 ^ t1_val[i]) & t1_msk[i]) == '0) begin
        hits[3] = 1'b1;
        tans1 = t1_ans[i];
      end
    end
    // Each hitting table contributes its action bits; ternary gives only its lowest hit (see RULE2)
    act = (hits[0] ? small0[sidx].ans : '0) | (hits[1] ? large0[lidx].ans : '0) | tans0 | tans1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state: AXI slave, staging window, lookup pipeline
  always_comb begin
    logic [`EAKL_ADDRW-1:0] wa;
    nx = st;
    wa = st.awaddr;
    nx.tbl_we = 1'b0;
    if (st.bvalid && s_axi_bready) nx.bvalid = 1'b0;
    if (s_axi_awvalid && st.awready) begin
      nx.aw_got = 1'b1;
      nx.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready) begin
      nx.w_got = 1'b1;
      nx.wdata = s_axi_wdata;
      nx.wstrb = s_axi_wstrb;
    end
    // Both halves held: commit and answer on the same edge
    if (st.aw_got && st.w_got && !st.bvalid) begin
      nx.aw_got = 1'b0;
      nx.w_got = 1'b0;
      nx.bvalid = 1'b1;
      nx.bresp = `EAKL_OKAY;
      if (wa == `EAKL_REG_CMD) begin
        nx.cmd = st.wdata;
        nx.tbl_we = 1'b1;
      end else if (wa >= `EAKL_REG_STAGE && wa < `EAKL_REG_STAGE + 12'(4 * `EAKL_NSTAGE)) begin
        for (int b = 0; b < 4; b++) begin
          if (st.wstrb[b]) nx.stage[6'((wa - `EAKL_REG_STAGE) >> 2)][b*8 +: 8] = st.wdata[b*8 +: 8];
        end
      end else if (wa != `EAKL_REG_STAT) begin
        nx.bresp = `EAKL_SLVERR;
      end
    end
    nx.awready = !nx.aw_got && !nx.bvalid;
    nx.wready = !nx.w_got && !nx.bvalid;
    // Read: one-cycle answer, held until taken
    if (st.rvalid && s_axi_rready) nx.rvalid = 1'b0;
    if (s_axi_arvalid && st.arready) begin
      nx.rvalid = 1'b1;
      nx.rresp = `EAKL_OKAY;
      nx.rdata = 32'h0000_0000;
      if (s_axi_araddr == `EAKL_REG_CMD) begin
        nx.rdata = st.cmd;
      end else if (s_axi_araddr == `EAKL_REG_STAT) begin
        nx.rdata = {9'h000, st.ptr1, 1'b0, st.ptr0, st.nlook};
      end else if (s_axi_araddr >= `EAKL_REG_STAGE &&
                   s_axi_araddr < `EAKL_REG_STAGE + 12'(4 * `EAKL_NSTAGE)) begin
        nx.rdata = st.stage[6'((s_axi_araddr - `EAKL_REG_STAGE) >> 2)];
      end else begin
        nx.rresp = `EAKL_SLVERR;
      end
    end
    nx.arready = !nx.rvalid;
    // Lookup pipeline: keys, then search result
    nx.s1_valid = pkt_valid;
    if (pkt_valid) begin
      nx.key0 = kraw0[`EAKL_KW0-1:0];
      nx.key1 = kraw1;
      nx.ptr0 = ptr[0];
      nx.ptr1 = ptr[1];
      nx.nlook = st.nlook + 16'h0001;
    end
    nx.res_valid = st.s1_valid;
    if (st.s1_valid) nx.res = '{hits: hits, action: act, ptr0: st.ptr0, ptr1: st.ptr1};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Table writes from the staging window; valid bits cleared at reset
  logic [`EAKL_NSTAGE*32-1:0] sv;
  logic [9:0] ix;
  logic v;
  assign sv = st.stage;
  assign ix = st.cmd[25:16]; // Table index field of the command word
  assign v = sv[`EAKL_ST_VLD];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_vld <= '0;
      small_vld <= '0;
      large_vld <= '0;
      t0_vld <= '0;
      t1_vld <= '0;
      smask0 <= '1;
    end else if (st.tbl_we) begin
      unique case (st.cmd[3:0])
        `EAKL_T_SEL: begin
          sel_val[ix[3:0]] <= sv[`EAKL_SELW-1:0];
          sel_msk[ix[3:0]] <= sv[`EAKL_ST_MSK +: `EAKL_SELW];
          sel_vld[ix[3:0]] <= v;
        end
        `EAKL_T_SANS0: sel_ans[0][ix[3:0]] <= sv[`EAKL_ST_ANS +: `EAKL_RPW];
        `EAKL_T_SANS1: sel_ans[1][ix[3:0]] <= sv[`EAKL_ST_ANS +: `EAKL_RPW];
        `EAKL_T_RULE0: rule_tab[0][ix[2:0]] <= sv[`EAKL_CHW-1:0];
        `EAKL_T_RULE1: rule_tab[1][ix[2:0]] <= sv[`EAKL_CHW-1:0];
        `EAKL_T_SMASK0: smask0 <= sv[`EAKL_KW0-1:0];
        `EAKL_T_SMALL0: begin
          small0[ix[7:0]] <= '{vld: v, key: sv[`EAKL_KW0-1:0], ans: sv[`EAKL_ST_ANS +: `EAKL_ANSW]};
          small_vld[ix[7:0]] <= v;
        end
        `EAKL_T_LARGE0: begin
          large0[ix] <= '{vld: v, key: sv[`EAKL_KW0-1:0], ans: sv[`EAKL_ST_ANS +: `EAKL_ANSW]};
          large_vld[ix] <= v;
        end
        `EAKL_T_TERN0: begin
          t0_val[ix[3:0]] <= sv[`EAKL_KW0-1:0];
          t0_msk[ix[3:0]] <= sv[`EAKL_ST_MSK +: `EAKL_KW0];
          t0_ans[ix[3:0]] <= sv[`EAKL_ST_ANS +: `EAKL_ANSW];
          t0_vld[ix[3:0]] <= v;
        end
        `EAKL_T_TERN1: begin
          t1_val[ix[3:0]] <= sv[`EAKL_KW1-1:0];
          t1_msk[ix[3:0]] <= sv[`EAKL_ST_MSK +: `EAKL_KW1]; // Low part of the mask region
          t1_ans[ix[3:0]] <= sv[`EAKL_ST_ANS +: `EAKL_ANSW];
          t1_vld[ix[3:0]] <= v;
        end
        default: ;
      endcase
    end
  end

  // Outputs straight from the state flops
  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign res_valid = st.res_valid;
  assign res_out = st.res;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_lat_two: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE1
    pkt_valid |-> ##2 res_valid) else $error("lookup result not two cycles after packet");
  chk_no_hit_ptr: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE8
    pkt_valid && !sel_hit |=> st.ptr0 == '0 && st.ptr1 == '0) else $error("miss gave nonzero rule pointer");
  chk_first_match: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE7
    pkt_valid && sel_hit |=> st.ptr0 == $past(sel_ans[0][sel_idx])) else $error("selector answer index wrong");
  chk_macda_key: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE16
    pkt_valid && rule_tab[0][ptr[0]] == 18'h00001 |=> st.key0[48:0] == {$past(pkt_in.mac_da), 1'b1})
    else $error("MAC DA key layout wrong");
  chk_ipv4_gate: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE15
    pkt_valid && rule_tab[0][ptr[0]] == 18'h00004 && pkt_in.l3_type != `EAKL_L3_IPV4 |=> !st.key0[0])
    else $error("IPv4 field valid on non-IPv4 packet");
  chk_l4type_key: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE20
    pkt_valid && rule_tab[0][ptr[0]] == 18'h04000 |=> st.key0[3:0] == {$past(pkt_in.l4_type), 1'b1})
    else $error("L4 type key layout wrong");
  chk_empty_key: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE23
    pkt_valid && rule_tab[1][ptr[1]] == 18'h00000 |=> st.key1 == '0) else $error("empty rule key not zero");
  chk_miss_action: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE2
    res_valid && res_out.hits == 4'h0 |-> res_out.action == '0) else $error("action without any hit");
endmodule
`default_nettype wire

// ==== eakl_consts.svh ====
// Constants of the egress ACL key lookup stage.
// Assumes inclusion by bare name from the package and the top module.
`ifndef EAKL_CONSTS_SVH
`define EAKL_CONSTS_SVH
`define EAKL_KW0 135
`define EAKL_KW1 540
`define EAKL_MAXF0 7
`define EAKL_MAXF1 20
`define EAKL_NFLD 18
`define EAKL_FDW 128
`define EAKL_FW_LIST '{48, 48, 32, 32, 128, 128, 16, 16, 12, 12, 6, 11, 8, 16, 3, 2, 4, 3}
`define EAKL_F_RPTR 17
`define EAKL_SELW 38
`define EAKL_NSEL 16
`define EAKL_NRULE 8
`define EAKL_RPW 3
`define EAKL_CHW 18
`define EAKL_NSMALL 256
`define EAKL_NLARGE 1024
`define EAKL_SIW 8
`define EAKL_LIW 10
`define EAKL_NTERN 16
`define EAKL_ANSW 16
`define EAKL_ADDRW 12
`define EAKL_REG_CMD 12'h000
`define EAKL_REG_STAT 12'h004
`define EAKL_REG_STAGE 12'h100
`define EAKL_NSTAGE 40
`define EAKL_ST_MSK 576
`define EAKL_ST_ANS 1152
`define EAKL_ST_VLD 1168
`define EAKL_T_SEL 4'h0
`define EAKL_T_SANS0 4'h1
`define EAKL_T_SANS1 4'h2
`define EAKL_T_RULE0 4'h3
`define EAKL_T_RULE1 4'h4
`define EAKL_T_SMASK0 4'h5
`define EAKL_T_SMALL0 4'h6
`define EAKL_T_LARGE0 4'h7
`define EAKL_T_TERN0 4'h8
`define EAKL_T_TERN1 4'h9
`define EAKL_OKAY 2'h0
`define EAKL_SLVERR 2'h2
`define EAKL_L3_IPV4 2'h0
`define EAKL_L3_IPV6 2'h1
`define EAKL_L4_UDP 3'h2
`define EAKL_L4_TCP 3'h3
`endif

// ==== eakl_pkg.sv ====
// Types of the egress ACL key lookup stage.
// Assumes eakl_consts.svh is on the include path.
`include "eakl_consts.svh"
package eakl_pkg;
  // Decoded packet fields from the packet decoder
  typedef struct packed {
    logic [47:0] mac_da;
    logic [47:0] mac_sa;
    logic [31:0] ipv4_sa;
    logic [31:0] ipv4_da;
    logic [127:0] ipv6_sa;
    logic [127:0] ipv6_da;
    logic [15:0] l4_sp;
    logic [15:0] l4_dp;
    logic [11:0] vlan_group_pointer;
    logic [11:0] vid;
    logic [5:0] mc_ptr;
    logic mc_used;
    logic [10:0] egress_port_bitmap;
    logic [7:0] l4_proto;
    logic [15:0] eth_type;
    logic [2:0] l4_type;
    logic [1:0] l3_type;
    logic [3:0] origin_port;
  } eakl_pkt_t;
  // Forwarding result searched by the rule selector
  typedef struct packed {
    logic [10:0] egress_port_bitmap;
    logic routed;
    logic [1:0] vrf;
    logic flooded;
    logic unicast_bridged_flag;
    logic multicast_bridged_flag;
    logic [11:0] vid;
    logic [1:0] l3_type;
    logic [2:0] l4_type;
    logic [3:0] origin_port;
  } eakl_fwd_t;
  // Combined lookup result
  typedef struct packed {
    logic [3:0] hits;
    logic [`EAKL_ANSW-1:0] action;
    logic [`EAKL_RPW-1:0] ptr0;
    logic [`EAKL_RPW-1:0] ptr1;
  } eakl_res_t;
  typedef struct packed {
    logic vld;
    logic [`EAKL_KW0-1:0] key;
    logic [`EAKL_ANSW-1:0] ans;
  } eakl_hent_t;
  // Flip-flop state of the top module apart from the tables
  typedef struct packed {
    logic awready, wready, bvalid, arready, rvalid, aw_got, w_got;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [`EAKL_ADDRW-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [31:0] cmd;
    logic tbl_we;
    logic [`EAKL_NSTAGE-1:0][31:0] stage;
    logic s1_valid;
    logic [`EAKL_KW0-1:0] key0;
    logic [`EAKL_KW1-1:0] key1;
    logic [`EAKL_RPW-1:0] ptr0, ptr1;
    logic res_valid;
    eakl_res_t res;
    logic [15:0] nlook;
  } eakl_state_t;
endpackage

// ==== eakl_fwd_model.sv ====
// Model of the packet decoder and forwarding logic ahead of the lookup.
// Assumes the bench raises go for one cycle per packet, back to back allowed.
`timescale 1ns/1ps
`default_nettype none
`include "eakl_consts.svh"
module eakl_fwd_model (
  input wire logic aclk,
  input wire logic go,
  input wire logic [47:0] mac,
  output logic pkt_valid,
  output eakl_pkg::eakl_pkt_t pkt_in,
  output eakl_pkg::eakl_fwd_t fwd_in
);
  import eakl_pkg::*;
  ////////////////////////////////////////////////////////////////
  // Start known so the idle inversion never leaves unknowns
  initial begin
    pkt_valid = 1'h0;
    pkt_in = '0;
    fwd_in = '0;
  end
  // Idle cycles flip the fields so stale data never looks current
  always @(posedge aclk) begin
    pkt_valid <= go;
    pkt_in <= ~pkt_in;
    fwd_in <= ~fwd_in;
    if (go) begin
      pkt_in <= '0;
      pkt_in.mac_da <= mac;
      pkt_in.l3_type <= mac[0] ? `EAKL_L3_IPV6 : `EAKL_L3_IPV4;
      pkt_in.l4_type <= `EAKL_L4_UDP;
      fwd_in <= '0;
      fwd_in.origin_port <= 4'h3;
    end
  end
endmodule
`default_nettype wire

// ==== eakl_top_bench.sv ====
// Self-checking bench of the egress ACL key lookup stage.
// Assumes the forwarding model feeds packets and AXI4-Lite fills the tables.
`timescale 1ns/1ps
`default_nettype none
`include "eakl_consts.svh"
module eakl_top_bench;
  import eakl_pkg::*;
  typedef struct packed {logic [47:0] mac; logic [3:0] hits; logic [15:0] act;} eakl_row_t;
  localparam logic [47:0] MAC_A = 48'hA1B2C3D4E5F6;
  localparam logic [15:0] ANS_A = 16'h5A3C;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic go = 1'h0;
  logic [47:0] mac = 48'h0;
  logic pkt_valid;
  eakl_pkt_t pkt_in;
  eakl_fwd_t fwd_in;
  logic res_valid;
  eakl_res_t res_out;
  logic [11:0] awaddr = 12'h0;
  logic [11:0] araddr = 12'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic awready;
  logic wready;
  logic bvalid;
  logic arready;
  logic rvalid;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic [31:0] rdata;
  logic [159:0] key;
  logic [31:0] rd_d;
  logic [1:0] rd_r;
  eakl_row_t rows [4];
  int n_mismatch = 0;
  int checks = 0;
  ////////////////////////////////////////////////////////////////
  // Clock at 25 MHz
  always #20 aclk = ~aclk;
  eakl_top dut_u (.aclk(aclk), .aresetn(aresetn), .pkt_valid(pkt_valid), .pkt_in(pkt_in),
    .fwd_in(fwd_in), .res_valid(res_valid), .res_out(res_out), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  eakl_fwd_model part_u (.aclk(aclk), .go(go), .mac(mac), .pkt_valid(pkt_valid),
    .pkt_in(pkt_in), .fwd_in(fwd_in));
  ////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    if (n_mismatch == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    checks++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      n_mismatch++;
    end
  endtask
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    bit ad;
    bit wd;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready && !ad) begin
        ad = 1;
        awvalid <= 1'h0;
      end
      if (wready && !wd) begin
        wd = 1;
        wvalid <= 1'h0;
      end
    end while (!(ad && wd));
    do @(posedge aclk); while (!bvalid);
    bready <= 1'h0;
    chk("bresp", er, bresp);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'h0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'h0;
    d = rdata;
    r = rresp;
  endtask
  task automatic tbl(input logic [3:0] t, input logic [9:0] idx);
    wr(`EAKL_REG_CMD, {6'h00, idx, 12'h000, t}, `EAKL_OKAY);
  endtask
  // One packet, then wait for its result pulse
  task automatic send(input logic [47:0] m);
    @(posedge aclk);
    go <= 1'h1;
    mac <= m;
    @(posedge aclk);
    go <= 1'h0;
    do @(posedge aclk); while (!res_valid);
  endtask
  // Small table index with the all-ones reset search mask
  function automatic logic [7:0] fold8(input logic [134:0] k);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 135; i++) begin
      r[i % 8] ^= k[i];
    end
    return r;
  endfunction
  ////////////////////////////////////////////////////////////////
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    rows[0] = '{MAC_A, 4'h1, ANS_A};
    rows[1] = '{MAC_A + 48'h1, 4'h0, 16'h0};
    rows[2] = '{MAC_A ^ 48'h800000000000, 4'h0, 16'h0};
    rows[3] = '{MAC_A, 4'h1, ANS_A};
    repeat (10) @(posedge aclk);
    chk("res_valid", 64'h0, res_valid);
    chk("bvalid", 64'h0, bvalid);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    // Rule 0 of engine 0 picks the destination MAC only; engine 1 picks nothing
    wr(`EAKL_REG_STAGE, 32'h1, `EAKL_OKAY);
    tbl(`EAKL_T_RULE0, 10'h0);
    wr(`EAKL_REG_STAGE, 32'h0, `EAKL_OKAY);
    tbl(`EAKL_T_RULE1, 10'h0);
    // Stored key: valid bit lowest, MAC above, zeros beyond
    key = {111'h0, MAC_A, 1'h1};
    for (int i = 0; i < 5; i++) begin
      wr(12'(`EAKL_REG_STAGE + 4 * i), key[32 * i +: 32], `EAKL_OKAY);
    end
    wr(12'(`EAKL_REG_STAGE + 4 * 36), {15'h0, 1'h1, ANS_A}, `EAKL_OKAY);
    tbl(`EAKL_T_SMALL0, {2'h0, fold8(key[134:0])});
    repeat (3) @(posedge aclk);
    foreach (rows[i]) begin
      send(rows[i].mac);
      chk("hits", rows[i].hits, res_out.hits);
      chk("action", rows[i].act, res_out.action);
      chk("ptr0", 64'h0, res_out.ptr0);
      chk("ptr1", 64'h0, res_out.ptr1);
    end
    // Back-to-back packets, hit then miss
    @(posedge aclk);
    go <= 1'h1;
    mac <= MAC_A;
    @(posedge aclk);
    mac <= MAC_A + 48'h1;
    @(posedge aclk);
    go <= 1'h0;
    do @(posedge aclk); while (!res_valid);
    chk("hits_b2b0", 64'h1, res_out.hits);
    @(posedge aclk);
    chk("res_valid_b2b", 64'h1, res_valid);
    chk("hits_b2b1", 64'h0, res_out.hits);
    // Lookup count, read-only status, unmapped place
    rd(`EAKL_REG_STAT, rd_d, rd_r);
    chk("stat", 64'h6, rd_d[18:0]);
    wr(`EAKL_REG_STAT, 32'hFFFFFFFF, `EAKL_OKAY);
    rd(`EAKL_REG_STAT, rd_d, rd_r);
    chk("stat_ro", 64'h6, rd_d[18:0]);
    wr(12'h0F0, 32'h1, `EAKL_SLVERR);
    rd(12'h0F0, rd_d, rd_r);
    chk("rresp", `EAKL_SLVERR, rd_r);
    chk("rdata", 64'h0, rd_d);
    // Selector: entries 2 and 4 both match, the lower one picks rule 1
    wr(`EAKL_REG_STAGE, 32'h3, `EAKL_OKAY);
    wr(`EAKL_REG_STAGE + 12'h004, 32'h0, `EAKL_OKAY);
    wr(12'(`EAKL_REG_STAGE + 4 * 18), 32'hF, `EAKL_OKAY);
    wr(12'(`EAKL_REG_STAGE + 4 * 36), 32'h00010001, `EAKL_OKAY);
    tbl(`EAKL_T_SEL, 10'h2);
    tbl(`EAKL_T_SANS0, 10'h2);
    wr(12'(`EAKL_REG_STAGE + 4 * 18), 32'h0, `EAKL_OKAY);
    wr(12'(`EAKL_REG_STAGE + 4 * 36), 32'h00010002, `EAKL_OKAY);
    tbl(`EAKL_T_SEL, 10'h4);
    tbl(`EAKL_T_SANS0, 10'h4);
    wr(12'(`EAKL_REG_STAGE + 4 * 36), 32'h00010000, `EAKL_OKAY);
    tbl(`EAKL_T_SANS1, 10'h2);
    wr(`EAKL_REG_STAGE, 32'h4000, `EAKL_OKAY);
    tbl(`EAKL_T_RULE0, 10'h1);
    send(MAC_A);
    chk("ptr0_sel", 64'h1, res_out.ptr0);
    chk("ptr1_sel", 64'h0, res_out.ptr1);
    chk("hits_sel", 64'h0, res_out.hits);
    // IPv4 source chosen on an IPv6 packet: valid bit must stay low
    wr(`EAKL_REG_STAGE, 32'h4, `EAKL_OKAY);
    tbl(`EAKL_T_RULE0, 10'h1);
    send(MAC_A + 48'h1);
    chk("hits_v6", 64'h0, res_out.hits);
    // Second reset clears table valid bits and the count
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    send(MAC_A);
    chk("hits_rst", 64'h0, res_out.hits);
    rd(`EAKL_REG_STAT, rd_d, rd_r);
    chk("stat_rst", 64'h1, rd_d[15:0]);
    tally_and_finish();
  end
endmodule
`default_nettype wire
